// ---- hw/sram_port.sv ----
`timescale 1ns/1ps
module sram_port #(
  parameter int DATA_W = sram_port_pkg::NARROW_DATA_W,
  parameter int ADDR_W = sram_port_pkg::NARROW_ADDR_W
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic k_rise,
  input wire logic kn_rise,
  input wire logic c_rise,
  input wire logic cn_rise,
  input wire logic single_clock_mode,
  input wire logic write_port_select_n,
  input wire logic read_port_select_n,
  input wire logic [DATA_W/sram_port_pkg::LANE_W-1:0] byte_lane_write_enable_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  output logic [DATA_W-1:0] rdata,
  output logic rdata_oe,
  output logic echo_strobe,
  output logic echo_strobe_n,
  output logic read_ready
);
  import sram_port_pkg::*;

  localparam int LANES = DATA_W / LANE_W;
  localparam int WORDS = 1 << ADDR_W;

  // ****************************************************************
  // Storage: one array per burst beat
  // ****************************************************************
  logic [DATA_W-1:0] beat0_mem [WORDS];
  logic [DATA_W-1:0] beat1_mem [WORDS];

  logic wr_pend_q;
  logic [DATA_W-1:0] wr_d0_q;
  logic [LANES-1:0] wr_be0_n_q;
  logic [DATA_W-1:0] rd_beat0_q;
  logic [DATA_W-1:0] rd_beat1_q;
  rd_state_t rd_state_q;
  rd_state_t rd_state_d;
  logic [DATA_W-1:0] rdata_q;
  logic rdata_oe_q;
  logic echo_q;
  logic out_pos;
  logic out_neg;
  logic rd_start;
  logic wr_commit;

  read_fifo_if #(.W(DATA_W)) rdq ();

  read_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(READ_FIFO_DEPTH)
  ) u_read_fifo (
    .clock(clock),
    .srst(srst),
    .port(rdq.store)
  );

  // Merge a new beat into a stored word under active-low lane enables
  function automatic logic [DATA_W-1:0] lane_merge(
    input logic [DATA_W-1:0] old_word,
    input logic [DATA_W-1:0] new_word,
    input logic [LANES-1:0] lane_n
  );
    logic [DATA_W-1:0] res;
    res = old_word;
    for (int i = 0; i < LANES; i++) begin
      if (!lane_n[i]) begin
        res[i*LANE_W +: LANE_W] = new_word[i*LANE_W +: LANE_W];
      end
    end
    return res;
  endfunction

  // ****************************************************************
  // Write port
  // ****************************************************************

  // First beat and its lane enables are taken at the K rise
  always_ff @(posedge clock) begin
    if (srst) begin
      wr_pend_q <= 1'b0;
      wr_d0_q <= '0;
      wr_be0_n_q <= '1;
    end else if (k_rise) begin
      wr_pend_q <= !write_port_select_n;
      if (!write_port_select_n) begin
        wr_d0_q <= wdata;
        wr_be0_n_q <= byte_lane_write_enable_n;
      end
    end else if (kn_rise) begin
      wr_pend_q <= 1'b0;
    end
  end

  // Second beat and write address arrive together on K#
  assign wr_commit = kn_rise && wr_pend_q;

  // Both beats land at once so a half-done write is never visible
  always_ff @(posedge clock) begin
    if (wr_commit) begin
      beat0_mem[addr] <= lane_merge(beat0_mem[addr], wr_d0_q, wr_be0_n_q);
      beat1_mem[addr] <= lane_merge(beat1_mem[addr], wdata,
                                    byte_lane_write_enable_n);
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************

  // Requests meeting a busy sequencer are refused; read_ready tells
  assign read_ready = (rd_state_q == RD_IDLE);
  assign rd_start = k_rise && !read_port_select_n && read_ready;

  // Read address is used only when the read port is selected
  always_ff @(posedge clock) begin
    if (rd_start) begin
      rd_beat0_q <= beat0_mem[addr];
      rd_beat1_q <= beat1_mem[addr];
    end
  end

  // Push the burst into the FIFO; a full FIFO stalls the sequencer
  always_comb begin
    rd_state_d = rd_state_q;
    case (rd_state_q)
      RD_IDLE: begin
        if (rd_start) begin
          rd_state_d = RD_BEAT0;
        end
      end
      RD_BEAT0: begin
        if (rdq.in_ready) begin
          rd_state_d = RD_BEAT1;
        end
      end
      RD_BEAT1: begin
        if (rdq.in_ready) begin
          rd_state_d = RD_IDLE;
        end
      end
      default: begin
        rd_state_d = RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rd_state_q <= RD_IDLE;
    end else begin
      rd_state_q <= rd_state_d;
    end
  end

  assign rdq.in_valid = (rd_state_q == RD_BEAT0) || (rd_state_q == RD_BEAT1);
  assign rdq.in_data = (rd_state_q == RD_BEAT1) ? rd_beat1_q : rd_beat0_q;

  // ****************************************************************
  // Output stage
  // ****************************************************************

  // Output clock pair, or K pair in single clock mode
  assign out_pos = single_clock_mode ? k_rise : c_rise;
  assign out_neg = single_clock_mode ? kn_rise : cn_rise;
  assign rdq.out_ready = out_pos || out_neg;

  // Drivers release at a positive output edge with nothing pending
  always_ff @(posedge clock) begin
    if (srst) begin
      rdata_q <= '0;
      rdata_oe_q <= 1'b0;
    end else if (out_pos || out_neg) begin
      if (rdq.out_valid) begin
        rdata_q <= rdq.out_data;
        rdata_oe_q <= 1'b1;
      end else if (out_pos) begin
        rdata_oe_q <= 1'b0;
      end
    end
  end

  // Echo strobes track the selected output clock pair
  always_ff @(posedge clock) begin
    if (srst) begin
      echo_q <= 1'b0;
    end else if (out_pos) begin
      echo_q <= 1'b1;
    end else if (out_neg) begin
      echo_q <= 1'b0;
    end
  end

  assign rdata = rdata_q;
  assign rdata_oe = rdata_oe_q;
  assign echo_strobe = echo_q;
  assign echo_strobe_n = !echo_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_write_req;
    k_rise && !write_port_select_n;
  endsequence

  sequence s_read_req;
    k_rise && !read_port_select_n && read_ready;
  endsequence

  a_write_first_beat: assert property (@(posedge clock) disable iff (srst)
    s_write_req |=> wr_pend_q && (wr_d0_q == $past(wdata)))
    else $error("first write beat not captured");

  a_write_deselect: assert property (@(posedge clock) disable iff (srst)
    k_rise && write_port_select_n |=> !wr_pend_q)
    else $error("deselected write port still pending");

  a_write_lanes: assert property (@(posedge clock) disable iff (srst)
    s_write_req |=> wr_be0_n_q == $past(byte_lane_write_enable_n))
    else $error("lane enables not taken with first beat");

  a_read_start: assert property (@(posedge clock) disable iff (srst)
    s_read_req |=> rd_state_q == RD_BEAT0)
    else $error("read request did not start burst");

  a_read_deselect: assert property (@(posedge clock) disable iff (srst)
    k_rise && read_port_select_n && read_ready |=> rd_state_q == RD_IDLE)
    else $error("deselected read port started a burst");

  a_read_two_beats: assert property (@(posedge clock) disable iff (srst)
    rd_state_q == RD_BEAT0 && rdq.in_ready |=> rd_state_q == RD_BEAT1
    ##0 rdq.in_valid)
    else $error("burst did not carry second beat");

  a_read_launch: assert property (@(posedge clock) disable iff (srst)
    (out_pos || out_neg) && rdq.out_valid |=> rdata_oe && rdata == $past(rdq.out_data))
    else $error("read beat not launched on output edge");

  a_read_tristate: assert property (@(posedge clock) disable iff (srst)
    out_pos && !rdq.out_valid |=> !rdata_oe)
    else $error("drivers not released after idle positive edge");

  a_oe_steady: assert property (@(posedge clock) disable iff (srst)
    !out_pos && !out_neg |=> $stable(rdata_oe) && $stable(rdata))
    else $error("read outputs moved between output edges");

  a_echo_align: assert property (@(posedge clock) disable iff (srst)
    out_pos |=> echo_strobe && !echo_strobe_n)
    else $error("echo strobe not aligned to output edge");
endmodule

// ---- inc/sram_port_pkg.sv ----
// What this block does
// - Capture write data on K and K# rises
// - Two internal arrays, 1Mx18 or 512Kx36
// - Address 19 bits narrow, 18 bits wide
// - Low write select at K starts write
// - High write select ignores write data
// - Low byte select writes its 9-bit lane
// - Byte selects sampled with each data beat
// - Read address on K, write on K#
// - Deselected port ignores its address
// - Read data launched on C and C# rises, or on K and K# in single clock mode
// - Deselected read port tristates outputs
// - Low read select at K starts read while read_ready is high
// - Pending read finishes, then tristate after C (after K in single clock mode)
// - Every read returns two sequential beats
// - Every access starts on K rise
// - Echo strobes follow output clock pair
package sram_port_pkg;
  // ****************************************************************
  // Organisation
  // ****************************************************************
  localparam int LANE_W = 9;
  localparam int NARROW_DATA_W = 18;
  localparam int NARROW_ADDR_W = 19;
  localparam int WIDE_DATA_W = 36;
  localparam int WIDE_ADDR_W = 18;
  localparam int BURST_LEN = 2;
  localparam int READ_FIFO_DEPTH = 16;
  localparam int CLOCK_PERIOD_NS = 25;

  // ****************************************************************
  // Read burst sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_BEAT0 = 2'b01,
    RD_BEAT1 = 2'b10
  } rd_state_t;
endpackage

// ---- inc/read_fifo_if.sv ----
`timescale 1ns/1ps
// Carries read beats from the burst sequencer to the output stage
interface read_fifo_if #(parameter int W = 18);
  logic [W-1:0] in_data;
  logic in_valid;
  logic in_ready;
  logic [W-1:0] out_data;
  logic out_valid;
  logic out_ready;
  modport fill(output in_data, output in_valid, input in_ready);
  modport drain(input out_data, input out_valid, output out_ready);
  modport store(input in_data, input in_valid, output in_ready,
                output out_data, output out_valid, input out_ready);
endinterface

// ---- hw/read_fifo.sv ----
`timescale 1ns/1ps
module read_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic srst,
  read_fifo_if.store port
);
  import sram_port_pkg::*;

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] slots_q [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [PW:0] count_q;
  logic push;
  logic pop;

  // Honest flags straight from the occupancy count
  assign port.in_ready = (count_q != (PW+1)'(DEPTH));
  assign port.out_valid = (count_q != '0);
  assign port.out_data = slots_q[rd_ptr_q];
  assign push = port.in_valid && port.in_ready;
  assign pop = port.out_valid && port.out_ready;

  // Storage holds no reset; only pointers and count need a defined state
  always_ff @(posedge clock) begin
    if (push) begin
      slots_q[wr_ptr_q] <= port.in_data;
    end
  end

  // Pointers wrap naturally when depth is a power of two
  always_ff @(posedge clock) begin
    if (srst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + PW'(1);
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + PW'(1);
      end
      count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

// ---- tb/out_clock_model.sv ----
`timescale 1ns/1ps
// Far-side controller: sources the output clock pair as one-cycle edge pulses
module out_clock_model (
  input wire logic clock,
  input wire logic hold,
  input wire logic [1:0] gap,
  output logic c_rise,
  output logic cn_rise
);
  // Outputs settle low at the first falling edge; only the always block drives them
  logic [1:0] wait_q = 2'h0;
  logic phase_q = 1'b0;
  // C then C#, spaced by gap to mimic board skew; hold parks both clocks low
  always @(negedge clock) begin
    c_rise <= 1'b0;
    cn_rise <= 1'b0;
    if (!hold && wait_q == 2'h0) begin
      c_rise <= !phase_q;
      cn_rise <= phase_q;
      phase_q <= !phase_q;
      wait_q <= gap;
    end else if (wait_q != 2'h0) begin
      wait_q <= wait_q - 2'h1;
    end
  end
endmodule

// ---- tb/tb_quad_rate_sram_port_pins.sv ----
`timescale 1ns/1ps
module tb_quad_rate_sram_port_pins;
  import sram_port_pkg::*;
  logic clock = 1'b0, srst = 1'b1, k_rise = 1'b0, kn_rise = 1'b0, single_clock_mode = 1'b0;
  logic write_port_select_n = 1'b1, read_port_select_n = 1'b1, hold = 1'b1;
  logic [1:0] be = 2'h3, gap = 2'h1;
  logic [18:0] addr = 19'h0;
  logic [17:0] wdata = 18'h0, rdata, mem0[int], mem1[int], exp_q[$];
  logic rdata_oe, echo_strobe, echo_strobe_n, read_ready, c_rise, cn_rise, p, n, pop, off;
  logic [31:0] seed = 32'hAD24E49C;
  int error_cnt = 0, checks_done = 0, avail = 0;
  always #(CLOCK_PERIOD_NS / 2.0) clock = ~clock;
  sram_port DUT (.clock(clock), .srst(srst), .k_rise(k_rise), .kn_rise(kn_rise),
    .c_rise(c_rise), .cn_rise(cn_rise), .single_clock_mode(single_clock_mode),
    .write_port_select_n(write_port_select_n), .read_port_select_n(read_port_select_n),
    .byte_lane_write_enable_n(be), .addr(addr), .wdata(wdata), .rdata(rdata),
    .rdata_oe(rdata_oe), .echo_strobe(echo_strobe), .echo_strobe_n(echo_strobe_n),
    .read_ready(read_ready));
  out_clock_model far (.clock(clock), .hold(hold), .gap(gap), .c_rise(c_rise),
    .cn_rise(cn_rise));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Lanes with enable high keep the old word, so the model merges per lane
  function automatic logic [17:0] mrg(logic [17:0] o, logic [17:0] d, logic [1:0] b);
    for (int l = 0; l < 2; l++) if (!b[l]) o[l*9 +: 9] = d[l*9 +: 9];
    return o;
  endfunction
  task automatic check(input string nm, input logic [17:0] seen, input logic [17:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Two-beat write; s=0 leaves the port deselected and the model untouched
  task automatic wr(input logic s, input logic [18:0] a, input logic [17:0] d0,
                    input logic [17:0] d1, input logic [1:0] b0, input logic [1:0] b1);
    k_rise = 1'b1; write_port_select_n = !s; wdata = d0; be = b0;
    @(negedge clock);
    k_rise = 1'b0; kn_rise = 1'b1; addr = a; wdata = d1; be = b1;
    if (s) mem0[a] = mrg(mem0[a], d0, b0);
    if (s) mem1[a] = mrg(mem1[a], d1, b1);
    @(negedge clock);
    kn_rise = 1'b0; write_port_select_n = 1'b1; wdata = ~wdata; be = ~be;
    @(negedge clock);
  endtask
  // Output clocks are parked while a read is taken so the beat count stays exact
  task automatic rd(input logic s, input logic [18:0] a);
    int i;
    hold <= 1'b1;
    i = 0;
    @(negedge clock);
    while (read_ready !== 1'b1 && i < 100) begin
      @(negedge clock);
      i++;
    end
    check("read_ready", read_ready, 18'h1);
    k_rise = 1'b1; read_port_select_n = !s; addr = a;
    if (s) exp_q.push_back(mem0[a]);
    if (s) exp_q.push_back(mem1[a]);
    @(negedge clock);
    k_rise = 1'b0; read_port_select_n = 1'b1; addr = 19'(rnd());
    repeat (3) @(negedge clock);
    if (s) avail += 2;
  endtask
  task automatic drain(input string nm);
    int i;
    hold <= 1'b0;
    for (i = 0; i < 400 && avail > 0; i++) @(negedge clock);
    check("drained", 18'(avail), 18'h0);
    repeat (12) @(negedge clock);
    $display("test %s done", nm);
  endtask
  // ****************************************************************
  // Output watcher: one beat per output edge while beats are owed
  // ****************************************************************
  always @(posedge clock) begin
    p = single_clock_mode ? k_rise : c_rise;
    n = single_clock_mode ? kn_rise : cn_rise;
    pop = !srst && (p || n) && avail > 0;
    off = !srst && p && avail == 0;
    if (pop) avail--;
    @(negedge clock);
    if (pop) check("rdata", rdata, exp_q.pop_front());
    if (pop) check("oe_on", rdata_oe, 18'h1);
    if (off) check("oe_off", rdata_oe, 18'h0);
    if (!srst && (p || n)) check("echo", {echo_strobe, echo_strobe_n}, p ? 2'b10 : 2'b01);
  end
  initial begin
    #(CLOCK_PERIOD_NS * 40000);
    error_cnt++;
    stop_test();
  end
  initial begin
    repeat (5) @(negedge clock);
    srst = 1'b0;
    check("reset", {rdata_oe, echo_strobe_n, read_ready}, 3'b011);
    for (int i = 0; i < 4; i++) wr(1'b1, 19'(i), 18'(rnd()), 18'(rnd()), 2'b00, 2'b00);
    wr(1'b1, 19'h7FFFF, 18'(rnd()), 18'(rnd()), 2'b00, 2'b00);
    rd(1'b1, 19'h7FFFF);
    rd(1'b1, 19'h0);
    drain("basic");
    wr(1'b1, 19'h1, 18'h3FFFF, 18'h3FFFF, 2'b10, 2'b01);
    rd(1'b1, 19'h1);
    drain("lanes");
    wr(1'b0, 19'h2, 18'(rnd()), 18'(rnd()), 2'b00, 2'b00);
    rd(1'b0, 19'h2);
    rd(1'b1, 19'h2);
    drain("deselect");
    for (int i = 0; i < 9; i++) rd(1'b1, 19'(i % 4));
    check("full_stall", read_ready, 18'h0);
    drain("fifo_full");
    single_clock_mode = 1'b1;
    rd(1'b1, 19'h3);
    repeat (3) begin
      k_rise = 1'b1;
      @(negedge clock);
      k_rise = 1'b0; kn_rise = 1'b1;
      @(negedge clock);
      kn_rise = 1'b0;
    end
    drain("single_clock");
    single_clock_mode = 1'b0;
    repeat (20) begin
      gap <= 2'(rnd());
      wr(1'b1, 19'(rnd() % 4), 18'(rnd()), 18'(rnd()), 2'(rnd()), 2'(rnd()));
      rd(1'b1, 19'(rnd() % 4));
      drain("random");
    end
    check("left", 18'(exp_q.size()), 18'h0);
    stop_test();
  end
endmodule
